/* File: design/timer_one_pkg.sv */
/*
    timer_one_pkg: register offsets, control field positions, reset values,
    mode codes and cycle counts for the sixteen bit timer/counter.
    Assumes a 20 MHz core clock and a 32-bit APB register bus.
*/
package timer_one_pkg;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] CTRL_OFFSET       = 8'h10;
    localparam logic [7:0] COUNT_LOW_OFFSET  = 8'h14;
    localparam logic [7:0] COUNT_HIGH_OFFSET = 8'h18;
    localparam logic [7:0] FLAG_OFFSET       = 8'h1C;
    localparam logic [7:0] ENABLE_OFFSET     = 8'h20;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int RUN_BIT        = 0;
    localparam int SOURCE_BIT     = 1;
    localparam int SYNC_BIT       = 2;
    localparam int OSC_BIT        = 3;
    localparam int PRESCALE_LO    = 4;
    localparam int PRESCALE_HI    = 5;
    localparam int CTRL_WIDTH     = 6;
    localparam int FLAG_BIT       = 0;
    localparam int IRQ_ENABLE_BIT = 0;

    // ************************************************************
    // reset values and codes
    // ************************************************************
    localparam logic [5:0]  CTRL_RESET           = 6'h00;
    localparam logic [15:0] COUNT_RESET          = 16'h0000;
    localparam logic [15:0] COUNT_MAX            = 16'hFFFF;
    localparam logic [2:0]  PRESCALE_RESET       = 3'h0;
    localparam logic [31:0] READ_ZERO            = 32'h0000_0000;
    localparam logic [3:0]  SPECIAL_TRIGGER_MODE = 4'hB;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLOCK_PERIOD_NS    = 50;
    localparam int INSTR_CYCLE_NS     = 200;
    localparam int INSTR_CYCLE_CLOCKS = (INSTR_CYCLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam logic [1:0] INSTR_DIV_LAST = 2'(INSTR_CYCLE_CLOCKS - 1);
    localparam logic [1:0] INSTR_DIV_RESET = 2'h0;

    typedef enum logic [1:0] {
        MODE_TIMER,
        MODE_SYNC_COUNTER,
        MODE_ASYNC_COUNTER
    } count_mode_t;

endpackage : timer_one_pkg

/* File: design/ext_edge_if.sv */
/*
    ext_edge_if: carries the raw external count level into the edge
    conditioner and the qualified rising-edge event back out.
    Assumes both ends run on the same core clock.
*/
`timescale 1ns/100ps
interface ext_edge_if;
    logic rawLevel;
    logic armEnable;
    logic riseEvt;

    modport conditioner (
        input  rawLevel,
        input  armEnable,
        output riseEvt
    );

    modport owner (
        output rawLevel,
        output armEnable,
        input  riseEvt
    );
endinterface : ext_edge_if

/* File: design/ext_edge_detect.sv */
/*
    ext_edge_detect: two-flop synchroniser for the external count level,
    falling-edge arming and rising-edge detection.
    Assumes rawLevel may change at any time relative to clock.
*/
`timescale 1ns/100ps
module ext_edge_detect (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        clkEn,
    ext_edge_if.conditioner  edgeBus
);

    typedef struct packed {
        logic syncFirst;
        logic syncSecond;
        logic prevLevel;
        logic armed;
    } edge_state_t;

    edge_state_t st_q;
    edge_state_t st_d;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        st_d            = st_q;
        st_d.syncFirst  = edgeBus.rawLevel;
        st_d.syncSecond = st_q.syncFirst;
        st_d.prevLevel  = st_q.syncSecond;
        // arm only after a falling edge once enabled
        st_d.armed      = edgeBus.armEnable & (st_q.armed | (st_q.prevLevel & ~st_q.syncSecond));
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
            st_q <= '0;
        else if (clkEn)
            st_q <= st_d;
    end

    assign edgeBus.riseEvt = st_q.armed & st_q.syncSecond & ~st_q.prevLevel;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    unarmed_no_edge_a : assert property (!st_q.armed |-> !edgeBus.riseEvt)
        else $error("rising edge passed before a falling edge");

    disarm_on_off_a : assert property (clkEn && !edgeBus.armEnable |=> !st_q.armed)
        else $error("edge detector stays armed while disabled");

endmodule : ext_edge_detect

/* File: design/timer_one_top.sv */
/*
    timer_one_top: sixteen bit up-counter with prescaler, clock source and
    synchronisation select, oscillator enable, overflow flag and trigger reset.
    Assumes an APB master on the core clock and compare-unit inputs on the
    same clock; the oscillator pins are sampled through ext_edge_detect.
*/
// Operation
// - 16-bit count in two byte registers
// - run bit 0 starts and stops counting
// - timer, synced counter, async counter modes
// - bit 1 selects instruction or external clock
// - timer mode counts each instruction cycle
// - counter mode counts external rising edges
// - first falling edge needed before counting
// - bit 3 enables the low power oscillator
// - oscillator enabled forces both pins input
// - oscillator and async count run in sleep
// - wrap from FFFFh sets overflow flag
// - enable bit gates interrupt, flag untouched
// - compare unit can clear the counter
// - trigger resets only under mode 1011
// - trigger reset never sets overflow flag
// - software count write beats trigger reset
`timescale 1ns/100ps
module timer_one_top (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        clkEn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sleep,
    input  wire logic [3:0]  compareModeCode,
    input  wire logic        compareTrigger,
    input  wire logic [1:0]  portCDirection,
    input  wire logic [1:0]  portCData,
    input  wire logic        oscInPin,
    input  wire logic        oscOutPinIn,
    output logic      [1:0]  pinOut,
    output logic      [1:0]  pinOe,
    output logic             oscEnable,
    output logic             overflowIrq
);

    typedef struct packed {
        logic [5:0]  ctrl;
        logic [15:0] count;
        logic        flag;
        logic        irqEn;
        logic [2:0]  pre;
        logic [1:0]  instrDiv;
        logic        syncPend;
        logic [31:0] rdata;
    } state_t;

    state_t st_q;
    state_t st_d;

    ext_edge_if edgeBus ();

    timer_one_pkg::count_mode_t mode;
    logic        instrTick;
    logic        access;
    logic        wrAccess;
    logic        wrLow;
    logic        wrHigh;
    logic        cntWrite;
    logic        trigReset;
    logic        countEvt;
    logic        runBit;
    logic [1:0]  prescale;
    logic [2:0]  preMask;
    logic        preTerminal;
    logic        incr;
    logic        wrap;
    logic        mapped;

    // ************************************************************
    // edge conditioner
    // ************************************************************
    ext_edge_detect edgeUnit (
        .clock   (clock),
        .rst_b   (rst_b),
        .clkEn   (clkEn),
        .edgeBus (edgeBus.conditioner)
    );

    // crystal amplifier input when the oscillator runs, else the count pin
    assign edgeBus.rawLevel  = st_q.ctrl[timer_one_pkg::OSC_BIT] ? oscInPin : oscOutPinIn;
    assign edgeBus.armEnable = runBit & st_q.ctrl[timer_one_pkg::SOURCE_BIT];

    // ************************************************************
    // decode
    // ************************************************************
    always_comb
    begin
        runBit   = st_q.ctrl[timer_one_pkg::RUN_BIT];
        prescale = st_q.ctrl[timer_one_pkg::PRESCALE_HI:timer_one_pkg::PRESCALE_LO];
        if (!st_q.ctrl[timer_one_pkg::SOURCE_BIT])
            mode = timer_one_pkg::MODE_TIMER;
        else if (st_q.ctrl[timer_one_pkg::SYNC_BIT])
            mode = timer_one_pkg::MODE_ASYNC_COUNTER;
        else
            mode = timer_one_pkg::MODE_SYNC_COUNTER;
        instrTick = (st_q.instrDiv == timer_one_pkg::INSTR_DIV_LAST);
        access    = psel & penable;
        wrAccess  = access & pwrite;
        wrLow     = wrAccess & (paddr == timer_one_pkg::COUNT_LOW_OFFSET);
        wrHigh    = wrAccess & (paddr == timer_one_pkg::COUNT_HIGH_OFFSET);
        cntWrite  = wrLow | wrHigh;
        trigReset = compareTrigger & (compareModeCode == timer_one_pkg::SPECIAL_TRIGGER_MODE);
        mapped    = (paddr == timer_one_pkg::CTRL_OFFSET) | (paddr == timer_one_pkg::COUNT_LOW_OFFSET)
                  | (paddr == timer_one_pkg::COUNT_HIGH_OFFSET) | (paddr == timer_one_pkg::FLAG_OFFSET)
                  | (paddr == timer_one_pkg::ENABLE_OFFSET);
        unique case (mode)
            timer_one_pkg::MODE_TIMER:        countEvt = instrTick & ~sleep;
            timer_one_pkg::MODE_SYNC_COUNTER: countEvt = (st_q.syncPend | edgeBus.riseEvt) & instrTick & ~sleep;
            timer_one_pkg::MODE_ASYNC_COUNTER: countEvt = edgeBus.riseEvt;
            default:                          countEvt = 1'b0;
        endcase
        // mask of prescale bits that must all be set for a count
        preMask     = {prescale == 2'h3, prescale[1], prescale != 2'h0};
        preTerminal = ((st_q.pre & preMask) == preMask);
        incr        = runBit & countEvt & preTerminal;
        wrap        = incr & (st_q.count == timer_one_pkg::COUNT_MAX);
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        st_d = st_q;

        // instruction cycle divider
        st_d.instrDiv = instrTick ? timer_one_pkg::INSTR_DIV_RESET : st_q.instrDiv + 2'h1;

        // external edge waits for the next instruction cycle when synced
        if (mode == timer_one_pkg::MODE_SYNC_COUNTER && runBit)
            st_d.syncPend = (st_q.syncPend | edgeBus.riseEvt) & ~(instrTick & ~sleep);
        else
            st_d.syncPend = 1'b0;

        // prescaler
        if (cntWrite)
            st_d.pre = timer_one_pkg::PRESCALE_RESET;
        else if (runBit & countEvt)
            st_d.pre = preTerminal ? timer_one_pkg::PRESCALE_RESET : st_q.pre + 3'h1;

        // counter: write beats trigger, trigger beats increment
        if (wrLow)
            st_d.count[7:0] = pwdata[7:0];
        else if (wrHigh)
            st_d.count[15:8] = pwdata[7:0];
        else if (trigReset)
            st_d.count = timer_one_pkg::COUNT_RESET;
        else if (incr)
            st_d.count = st_q.count + 16'h0001;

        // control and enable registers
        if (wrAccess && paddr == timer_one_pkg::CTRL_OFFSET)
            st_d.ctrl = pwdata[timer_one_pkg::CTRL_WIDTH-1:0];
        if (wrAccess && paddr == timer_one_pkg::ENABLE_OFFSET)
            st_d.irqEn = pwdata[timer_one_pkg::IRQ_ENABLE_BIT];

        // overflow flag: write one clears, a wrap in the same cycle wins
        if (wrAccess && paddr == timer_one_pkg::FLAG_OFFSET && pwdata[timer_one_pkg::FLAG_BIT])
            st_d.flag = 1'b0;
        if (wrap && !cntWrite && !trigReset)
            st_d.flag = 1'b1;

        // read data captured in the setup cycle
        if (psel && !penable)
        begin
            st_d.rdata = timer_one_pkg::READ_ZERO;
            unique case (1'b1)
                paddr == timer_one_pkg::CTRL_OFFSET:       st_d.rdata[5:0] = st_q.ctrl;
                paddr == timer_one_pkg::COUNT_LOW_OFFSET:  st_d.rdata[7:0] = st_q.count[7:0];
                paddr == timer_one_pkg::COUNT_HIGH_OFFSET: st_d.rdata[7:0] = st_q.count[15:8];
                paddr == timer_one_pkg::FLAG_OFFSET:       st_d.rdata[timer_one_pkg::FLAG_BIT] = st_q.flag;
                paddr == timer_one_pkg::ENABLE_OFFSET:     st_d.rdata[timer_one_pkg::IRQ_ENABLE_BIT] = st_q.irqEn;
                default:                                   st_d.rdata = timer_one_pkg::READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            st_q          <= '0;
            st_q.ctrl     <= timer_one_pkg::CTRL_RESET;
            st_q.count    <= timer_one_pkg::COUNT_RESET;
            st_q.pre      <= timer_one_pkg::PRESCALE_RESET;
            st_q.instrDiv <= timer_one_pkg::INSTR_DIV_RESET;
            st_q.rdata    <= timer_one_pkg::READ_ZERO;
        end
        else if (clkEn)
            st_q <= st_d;
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign prdata      = st_q.rdata;
    assign pready      = access;
    assign pslverr     = access & ~mapped;
    assign oscEnable   = st_q.ctrl[timer_one_pkg::OSC_BIT];
    assign overflowIrq = st_q.flag & st_q.irqEn;
    assign pinOut      = portCData;
    // oscillator forces both pins to inputs whatever the direction bits say
    assign pinOe       = oscEnable ? 2'h0 : ~portCDirection;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    count_wrap_a : assert property (clkEn && incr && st_q.count == 16'hFFFF && !cntWrite && !trigReset
                                    |=> st_q.count == 16'h0000 && st_q.flag)
        else $error("wrap did not clear count and set flag");

    run_stop_a : assert property (clkEn && !runBit && !cntWrite && !trigReset
                                  |=> st_q.count == $past(st_q.count))
        else $error("count moved while stopped");

    irq_gate_a : assert property (st_q.flag && !st_q.irqEn
                                  && !(wrAccess && paddr == timer_one_pkg::FLAG_OFFSET)
                                  |-> !overflowIrq ##1 st_q.flag)
        else $error("mask affected request or flag");

    trig_clear_a : assert property (clkEn && compareTrigger && compareModeCode == 4'hB && !cntWrite
                                    |=> st_q.count == 16'h0000)
        else $error("trigger did not clear counter");

    trig_noflag_a : assert property (clkEn && trigReset && !st_q.flag |=> !st_q.flag)
        else $error("trigger reset set overflow flag");

    write_wins_a : assert property (clkEn && trigReset && wrLow
                                    |=> st_q.count[7:0] == $past(pwdata[7:0]))
        else $error("trigger beat software write");

    timer_rate_a : assert property (runBit && mode == timer_one_pkg::MODE_TIMER && prescale == 2'h0
                                    && !sleep && instrTick |-> incr)
        else $error("timer missed an instruction cycle");

    prescale_eight_a : assert property (prescale == 2'h3 && incr |-> st_q.pre == 3'h7)
        else $error("divide by eight counted early");

    osc_pins_a : assert property (oscEnable |-> pinOe == 2'h0)
        else $error("pin driven while oscillator enabled");

endmodule : timer_one_top

/* File: sim/ext_clock_source.sv */
/*
    ext_clock_source: behavioural far-side count clock, either the external
    count pin driver or the low power crystal, sending bursts of pulses.
    Assumes the bench pulses start for one cycle of the core clock.
*/
`timescale 1ns/100ps
module ext_clock_source (
    input  wire logic       clock,
    input  wire logic       start,
    input  wire logic [7:0] pulses,
    input  wire logic [7:0] halfCycles,
    output logic            level,
    output logic            busy
);
    // ************************************************************
    // burst generator
    // ************************************************************
    int edgesLeft = 0;
    int holdLeft  = 0;

    // line idles low and stands still between bursts
    initial
    begin
        level = 1'b0;
        busy  = 1'b0;
    end

    // each pulse is a rise then a fall, each level held halfCycles clocks
    always @(posedge clock)
    begin
        if (start && !busy)
        begin
            edgesLeft <= 2 * pulses;
            holdLeft  <= halfCycles;
            busy      <= 1'b1;
        end
        else if (busy && holdLeft > 1)
            holdLeft <= holdLeft - 1;
        else if (busy && edgesLeft == 0)
            busy <= 1'b0;
        else if (busy)
        begin
            level     <= ~level;
            edgesLeft <= edgesLeft - 1;
            holdLeft  <= halfCycles;
        end
    end
endmodule : ext_clock_source

/* File: sim/sixteen_bit_timer_counter_tb_top.sv */
/*
    sixteen_bit_timer_counter_tb_top: self-checking bench, APB master,
    timer, counter, overflow, trigger and pin scenarios.
    Assumes timer_one_pkg, ext_edge_if, ext_edge_detect, timer_one_top.
*/
`timescale 1ns/100ps
module sixteen_bit_timer_counter_tb_top;
    localparam logic [7:0] A_CT = timer_one_pkg::CTRL_OFFSET;
    localparam logic [7:0] A_LO = timer_one_pkg::COUNT_LOW_OFFSET;
    localparam logic [7:0] A_HI = timer_one_pkg::COUNT_HIGH_OFFSET;
    localparam logic [7:0] A_FL = timer_one_pkg::FLAG_OFFSET;
    localparam logic [7:0] A_EN = timer_one_pkg::ENABLE_OFFSET;

    logic        clock = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clkEn = 1'b1;
    logic        sleep = 1'b0, compareTrigger = 1'b0, pready, pslverr, oscEnable, overflowIrq;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd, cnt;
    logic [3:0]  compareModeCode = 4'h0;
    logic [1:0]  portCDirection = 2'b11, portCData = 2'b00, pinOut, pinOe;
    logic [1:0]  srcStart = 2'b00, srcLevel, srcBusy;
    logic [7:0]  srcPulses = 8'h00;
    logic        err;
    int          miscompares = 0;
    int          nCompared = 0;

    always #25 clock = ~clock;

    timer_one_top timer_one_top_i (.clock(clock), .rst_b(rst_b), .clkEn(clkEn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep(sleep), .compareModeCode(compareModeCode),
        .compareTrigger(compareTrigger), .portCDirection(portCDirection), .portCData(portCData),
        .oscInPin(srcLevel[1]), .oscOutPinIn(srcLevel[0]), .pinOut(pinOut), .pinOe(pinOe),
        .oscEnable(oscEnable), .overflowIrq(overflowIrq));

    // src 0 drives the count pin, src 1 plays the crystal
    ext_clock_source pinSrc (.clock(clock), .start(srcStart[0]), .pulses(srcPulses), .halfCycles(8'h0A),
        .level(srcLevel[0]), .busy(srcBusy[0]));
    ext_clock_source xtalSrc (.clock(clock), .start(srcStart[1]), .pulses(srcPulses), .halfCycles(8'h0A),
        .level(srcLevel[1]), .busy(srcBusy[1]));

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic close_out;
        if (miscompares == 0 && nCompared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        nCompared++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : chk

    task automatic chkNear(input string nm, input logic [31:0] e, input logic [31:0] g);
        logic ok;
        ok = (g >= e - 32'(e != 0)) && (g <= e + 1);
        nCompared++;
        if (ok !== 1'b1)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : chkNear

    // one APB transfer; trg raises the trigger for the access cycle
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic trg);
        int n;
        n = 0;
        @(posedge clock);
        psel    <= 1'b1;
        paddr   <= a;
        pwrite  <= wr;
        pwdata  <= d;
        @(posedge clock);
        penable        <= 1'b1;
        compareTrigger <= trg;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rd             = prdata;
        err            = pslverr;
        psel           <= 1'b0;
        penable        <= 1'b0;
        compareTrigger <= 1'b0;
        if (n >= 16)
            chk("pready", 32'h0000_0001, 32'h0000_0000);
    endtask : xfer

    task automatic rd16;
        xfer(1'b0, A_LO, 32'h0000_0000, 1'b0);
        cnt = {24'h00_0000, rd[7:0]};
        xfer(1'b0, A_HI, 32'h0000_0000, 1'b0);
        cnt[15:8] = rd[7:0];
    endtask : rd16

    task automatic setCount(input logic [15:0] v);
        xfer(1'b1, A_LO, {24'h00_0000, v[7:0]}, 1'b0);
        xfer(1'b1, A_HI, {24'h00_0000, v[15:8]}, 1'b0);
    endtask : setCount

    task automatic burst(input int sel, input logic [7:0] n);
        int w;
        w = 0;
        srcPulses     <= n;
        srcStart[sel] <= 1'b1;
        @(posedge clock);
        srcStart[sel] <= 1'b0;
        do
        begin
            @(posedge clock);
            w++;
        end
        while (srcBusy[sel] && w < 4000);
    endtask : burst

    // ************************************************************
    // scenarios
    // ************************************************************
    initial
    begin
        logic [7:0]  regs [5];
        logic [15:0] v;
        logic [7:0]  cc [5];
        int          sel [5], slp [5], np [5], ex [5];
        regs = '{A_CT, A_LO, A_HI, A_FL, A_EN};
        cc   = '{8'h03, 8'h23, 8'h03, 8'h07, 8'h0F};
        sel  = '{0, 0, 0, 0, 1};
        slp  = '{0, 0, 1, 1, 1};
        np   = '{5, 9, 5, 5, 5};
        ex   = '{4, 2, 0, 4, 4};
        void'($urandom(14));
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            xfer(1'b0, regs[i], 32'h0000_0000, 1'b0);
            chk("reset value", 32'h0000_0000, rd);
        end
        xfer(1'b0, 8'h04, 32'h0000_0000, 1'b0);
        chk("unmapped err", 32'h0000_0001, 32'(err));
        xfer(1'b1, A_CT, 32'h0000_00FF, 1'b0);
        xfer(1'b0, A_CT, 32'h0000_0000, 1'b0);
        chk("ctrl readback", 32'h0000_003F, rd);
        xfer(1'b1, A_CT, 32'h0000_0000, 1'b0);
        v = 16'($urandom);
        setCount(v);
        rd16();
        chk("count readback", 32'(v), cnt);
        // timer mode, every prescale code, then one row asleep
        for (int i = 0; i < 5; i++)
        begin
            setCount(16'h0000);
            sleep <= (i == 4);
            xfer(1'b1, A_CT, 32'h0000_0001 | 32'((i % 4) << 4), 1'b0);
            repeat (128 << (i % 4)) @(posedge clock);
            xfer(1'b1, A_CT, 32'((i % 4) << 4), 1'b0);
            rd16();
            chkNear("timer count", (i == 4) ? 32'h0 : 32'h20, cnt);
            v = cnt[15:0];
            repeat (20) @(posedge clock);
            rd16();
            chk("stopped count", 32'(v), cnt);
        end
        sleep <= 1'b0;
        // clock enable low freezes a running timer
        setCount(16'h0000);
        xfer(1'b1, A_CT, 32'h0000_0001, 1'b0);
        clkEn <= 1'b0;
        repeat (400) @(posedge clock);
        clkEn <= 1'b1;
        xfer(1'b1, A_CT, 32'h0000_0000, 1'b0);
        rd16();
        chkNear("frozen count", 32'h0000_0000, cnt);
        setCount(16'hFFFF);
        xfer(1'b1, A_EN, 32'h0000_0001, 1'b0);
        xfer(1'b1, A_CT, 32'h0000_0001, 1'b0);
        repeat (12) @(posedge clock);
        chk("irq raised", 32'h0000_0001, 32'(overflowIrq));
        xfer(1'b1, A_CT, 32'h0000_0000, 1'b0);
        rd16();
        chk("wrapped high", 32'h0000_0000, {24'h00_0000, cnt[15:8]});
        xfer(1'b1, A_EN, 32'h0000_0000, 1'b0);
        @(posedge clock);
        chk("irq masked", 32'h0000_0000, 32'(overflowIrq));
        xfer(1'b0, A_FL, 32'h0000_0000, 1'b0);
        chk("flag kept", 32'h0000_0001, rd);
        xfer(1'b1, A_FL, 32'h0000_0001, 1'b0);
        xfer(1'b0, A_FL, 32'h0000_0000, 1'b0);
        chk("flag cleared", 32'h0000_0000, rd);
        // trigger, used with the counter in timer mode
        setCount(16'h1234);
        compareModeCode <= 4'($urandom % 11);
        xfer(1'b0, A_FL, 32'h0000_0000, 1'b1);
        rd16();
        chk("other mode kept", 32'h0000_1234, cnt);
        setCount(16'hFFFF);
        compareModeCode <= timer_one_pkg::SPECIAL_TRIGGER_MODE;
        xfer(1'b0, A_FL, 32'h0000_0000, 1'b1);
        rd16();
        chk("trigger cleared", 32'h0000_0000, cnt);
        xfer(1'b0, A_FL, 32'h0000_0000, 1'b0);
        chk("trigger no flag", 32'h0000_0000, rd);
        xfer(1'b1, A_LO, 32'h0000_0077, 1'b1);
        xfer(1'b0, A_LO, 32'h0000_0000, 1'b0);
        chk("write beats trigger", 32'h0000_0077, rd);
        compareModeCode <= 4'h0;
        // counter modes: first rise is not counted until a fall arms
        for (int i = 0; i < 5; i++)
        begin
            setCount(16'h0000);
            sleep <= 1'(slp[i]);
            xfer(1'b1, A_CT, 32'(cc[i]), 1'b0);
            burst(sel[i], 8'(np[i]));
            repeat (20) @(posedge clock);
            xfer(1'b1, A_CT, 32'h0000_0000, 1'b0);
            sleep <= 1'b0;
            rd16();
            chk("counter count", 32'(ex[i]), cnt);
        end
        portCDirection <= 2'($urandom);
        portCData      <= 2'($urandom);
        repeat (2) @(posedge clock);
        chk("pin oe", 32'({~portCDirection}), 32'(pinOe));
        chk("pin out", 32'(portCData), 32'(pinOut));
        xfer(1'b1, A_CT, 32'h0000_0008, 1'b0);
        @(posedge clock);
        chk("osc on", 32'h0000_0001, 32'(oscEnable));
        chk("pins input", 32'h0000_0000, 32'(pinOe));
        xfer(1'b1, A_CT, 32'h0000_0000, 1'b0);
        @(posedge clock);
        chk("osc off", 32'h0000_0000, 32'(oscEnable));
        close_out();
    end

    initial
    begin
        repeat (40000) @(posedge clock);
        miscompares++;
        close_out();
    end
endmodule : sixteen_bit_timer_counter_tb_top
